// ---- inc/tpf_pkg.sv ----
/*
 * shared constants and carriers of the header framer.
 * assumes a 32-bit apb master and one emulated_circuit_flow.
 */
package tpf_pkg;
	// ************************************
	// register byte offsets
	// ************************************
	localparam logic [7:0] TPF_A_CTRL  = 8'h00;
	localparam logic [7:0] TPF_A_SRCIP = 8'h04;
	localparam logic [7:0] TPF_A_DSTIP = 8'h08;
	localparam logic [7:0] TPF_A_PORTS = 8'h0c;
	localparam logic [7:0] TPF_A_IPCFG = 8'h10;
	localparam logic [7:0] TPF_A_SSRC  = 8'h14;
	localparam logic [7:0] TPF_A_STAT  = 8'h18;
	localparam logic [7:0] TPF_A_SEQ   = 8'h1c;
	// ctrl bit positions
	localparam int TPF_C_RTP  = 0;
	localparam int TPF_C_STR  = 1;
	localparam int TPF_C_AIS  = 2;
	localparam int TPF_C_SRC  = 3;
	localparam int TPF_C_PT   = 4;
	localparam int TPF_C_VER  = 8;
	// ipcfg field lsbs
	localparam int TPF_F_TTL  = 0;
	localparam int TPF_F_TOS  = 8;
	localparam int TPF_F_PT   = 16;
	localparam int TPF_F_PPT  = 24;
	// ************************************
	// header constants
	// ************************************
	localparam logic [3:0]  TPF_IPV4    = 4'h4;
	localparam logic [3:0]  TPF_IHL     = 4'h5;
	localparam logic [2:0]  TPF_DF      = 3'b010;
	localparam logic [7:0]  TPF_UDP     = 8'h11;
	localparam logic [1:0]  TPF_RTPV    = 2'h2;
	localparam logic [15:0] TPF_MINPORT = 16'h0400;
	localparam logic [15:0] TPF_L_IP    = 16'h0014;
	localparam logic [15:0] TPF_L_UDPCW = 16'h000c;
	localparam logic [15:0] TPF_L_RTP   = 16'h000c;
	localparam logic [3:0]  TPF_W_NORTP = 4'h7;
	localparam logic [3:0]  TPF_W_RTP   = 4'ha;
	localparam logic [1:0]  TPF_K_NORM  = 2'b00;
	localparam logic [1:0]  TPF_K_RAI   = 2'b10;
	localparam logic [1:0]  TPF_K_SIG   = 2'b11;
	// drop reason bits
	localparam int TPF_D_TTL  = 0;
	localparam int TPF_D_VER  = 1;
	localparam int TPF_D_PORT = 2;
	localparam int TPF_D_SRC  = 3;
	localparam int TPF_D_PT   = 4;
	// reset values
	localparam logic [7:0]  TPF_TTL_RST  = 8'h40;
	localparam logic [15:0] TPF_PORT_RST = 16'hc000;
	// per-flow configuration
	typedef struct packed {
		logic        rtp_en;
		logic        structured;
		logic        ais_fault;
		logic        src_chk;
		logic        pt_chk;
		logic [3:0]  ver;
		logic [15:0] lport;
		logic [15:0] rport;
		logic [31:0] sip;
		logic [31:0] dip;
		logic [31:0] ssrc;
		logic [7:0]  ttl;
		logic [7:0]  tos;
		logic [6:0]  pt;
		logic [6:0]  peer_pt;
	} tpf_cfg_s;
	localparam tpf_cfg_s TPF_CFG_RST = '{ver: TPF_IPV4,
		lport: TPF_PORT_RST, rport: TPF_PORT_RST,
		ttl: TPF_TTL_RST, default: '0};
	// tdm and packet fault levels
	typedef struct packed {
		logic los;
		logic oof;
		logic ais;
		logic pkt_loss;
	} tpf_flt_s;
	typedef enum logic [1:0] {
		TPF_TX_IDLE = 2'b00,
		TPF_TX_EMIT = 2'b01
	} tpf_tx_e;
endpackage

// ---- hw/tpf_framer.sv ----
/*
 * header framer of one emulated_circuit_flow: builds transmit
 * headers as 32-bit words, checks received header words.
 * assumes apb master, header-only word streams, synchronous inputs.
 */
`timescale 1ns/1ps

// Functional notes
// RQ1 - headers ip, udp, control word, rtp
// RQ2 - ip version per flow, both ways; the flow is held to ipv4, since ctrl writes with any other version are refused
// RQ3 - zero ttl datagram dropped
// RQ4 - ipv4 flags always 010
// RQ5 - peer gives unique dynamic destination ports
// RQ6 - receive steered by destination port
// RQ7 - well-known port configuration refused
// RQ8 - udp length counts header onward
// RQ9 - udp checksum sent as zero
// RQ10 - leading reserved nibble sent zero
// RQ11 - unstructured fault on los, optional ais
// RQ12 - structured fault on los, oof, ais
// RQ13 - fault flag clears with fault
// RQ14 - remote flag follows packet_loss_state
// RQ15 - kind coding with fault clear
// RQ16 - kind forced 00 with fault
// RQ17 - reserved byte sent zero
// RQ18 - sequence per flow and space
// RQ19 - rtp fixed version and zero bits
// RQ20 - payload type from config, optional check
// RQ21 - rtp sequence equals control word
// RQ22 - rtp timestamp per packet
// RQ23 - unmatched port leaves flow untouched
module tpf_framer #(
	parameter int CNT_W = 16
) (
	// clock and reset
	input  wire logic           core_clk,
	input  wire logic           arst_n,
	// apb slave
	input  wire logic           psel,
	input  wire logic           penable,
	input  wire logic           pwrite,
	input  wire logic [7:0]     paddr,
	input  wire logic [31:0]    pwdata,
	output logic                pready,
	output logic                pslverr,
	output logic [31:0]         prdata,
	// fault detectors
	input  tpf_pkg::tpf_flt_s   flt,
	// transmit request
	input  wire logic           tx_start,
	input  wire logic [1:0]     tx_kind,
	input  wire logic [15:0]    tx_len,
	// header words out
	output logic                tx_valid,
	output logic [31:0]         tx_data,
	output logic                tx_last,
	input  wire logic           tx_ready,
	// header words in
	input  wire logic           rx_valid,
	input  wire logic [31:0]    rx_data,
	input  wire logic           rx_last,
	// receive verdict
	output logic                rx_ok,
	output logic                rx_drop,
	output logic [4:0]          rx_why,
	output logic [1:0]          rx_kind
);
	// ************************************
	// state
	// ************************************
	typedef struct packed {
		tpf_pkg::tpf_cfg_s cfg;   // flow config
		logic              rdy;   // apb answer
		logic              err;
		logic [31:0]       rdat;
		tpf_pkg::tpf_tx_e  tx_st; // transmit fsm
		logic [3:0]        idx;   // word shown
		logic              rtp;   // packet latches
		logic [1:0]        kind;
		logic              lf_p;
		logic              rf_p;
		logic [15:0]       len;
		logic [15:0]       seq;
		logic [15:0]       id;
		logic [31:0]       ts;
		logic [15:0]       seq_d; // data space
		logic [15:0]       seq_s; // signaling space
		logic [31:0]       ts_ctr;
		logic              vld;
		logic              last;
		logic [31:0]       dat;
		logic              lf;    // local fault
		logic              rf;    // remote fault
		logic [3:0]        ridx;  // rx word index
		logic [4:0]        bad;
		logic [1:0]        rkind;
		logic [15:0]       rseq;
		logic [1:0]        seen;
		logic [15:0]       exp0;
		logic [15:0]       exp1;
		logic [CNT_W-1:0]  lost;
		logic [CNT_W-1:0]  reord;
		logic              ok;
		logic              drop;
		logic [4:0]        why;
	} tpf_st_s;

	localparam tpf_st_s ST_RST = '{cfg: tpf_pkg::TPF_CFG_RST,
		tx_st: tpf_pkg::TPF_TX_IDLE, default: '0};

	tpf_st_s     s;   // registered state
	tpf_st_s     n;   // next state
	logic [31:0] rd;  // read mux
	logic        hit; // mapped address
	logic        wok; // write allowed

	// counters wider than the read field cannot be shown
	if (CNT_W < 1 || CNT_W > 16) begin : g_chk
		$error("CNT_W must be 1 to 16");
	end

	// ************************************
	// header word builder
	// ************************************
	// one word per index, from packet latches and flow config
	function automatic logic [31:0] tpf_word(tpf_st_s t);
		logic [15:0] udp;
		logic [15:0] tl;
		logic [19:0] cs;
		logic [31:0] w;
		// RQ8 udp length field
		udp = tpf_pkg::TPF_L_UDPCW + t.len
			+ (t.rtp ? tpf_pkg::TPF_L_RTP : 16'h0000);
		tl = tpf_pkg::TPF_L_IP + udp;
		// ones-complement sum, folded twice
		cs = {4'h0, tpf_pkg::TPF_IPV4, tpf_pkg::TPF_IHL, t.cfg.tos}
			+ {4'h0, tl} + {4'h0, t.id}
			+ {4'h0, tpf_pkg::TPF_DF, 13'h0000}
			+ {4'h0, t.cfg.ttl, tpf_pkg::TPF_UDP}
			+ {4'h0, t.cfg.sip[31:16]} + {4'h0, t.cfg.sip[15:0]}
			+ {4'h0, t.cfg.dip[31:16]} + {4'h0, t.cfg.dip[15:0]};
		cs = {4'h0, cs[15:0]} + {16'h0000, cs[19:16]};
		cs = {4'h0, cs[15:0]} + {16'h0000, cs[19:16]};
		// RQ1 fixed word order
		case (t.idx)
			4'h0: w = {tpf_pkg::TPF_IPV4, tpf_pkg::TPF_IHL,
				t.cfg.tos, tl};
			// RQ4 don't-fragment flags
			4'h1: w = {t.id, tpf_pkg::TPF_DF, 13'h0000};
			4'h2: w = {t.cfg.ttl, tpf_pkg::TPF_UDP, ~cs[15:0]};
			4'h3: w = t.cfg.sip;
			4'h4: w = t.cfg.dip;
			4'h5: w = {t.cfg.lport, t.cfg.rport};
			// RQ9 checksum not computed
			4'h6: w = {udp, 16'h0000};
			// RQ10 RQ17 reserved fields zero
			4'h7: w = {4'h0, t.lf_p, t.rf_p, t.kind, 8'h00, t.seq};
			// RQ19 RQ20 RQ21 fixed rtp bits
			4'h8: w = {tpf_pkg::TPF_RTPV, 7'h00, t.cfg.pt, t.seq};
			4'h9: w = t.ts;
			default: w = t.cfg.ssrc;
		endcase
		return w;
	endfunction

	// ************************************
	// register read and write check
	// ************************************
	// read mux and refusal of bad writes
	always_comb begin
		rd  = 32'h0000_0000;
		hit = 1'b1;
		wok = 1'b1;
		if (paddr == tpf_pkg::TPF_A_CTRL) begin
			rd = {20'h00000, s.cfg.ver, 3'h0, s.cfg.pt_chk,
				s.cfg.src_chk, s.cfg.ais_fault,
				s.cfg.structured, s.cfg.rtp_en};
			// RQ2 only ipv4 served
			wok = pwdata[tpf_pkg::TPF_C_VER +: 4]
				== tpf_pkg::TPF_IPV4;
		end else if (paddr == tpf_pkg::TPF_A_SRCIP) begin
			rd = s.cfg.sip;
		end else if (paddr == tpf_pkg::TPF_A_DSTIP) begin
			rd = s.cfg.dip;
		end else if (paddr == tpf_pkg::TPF_A_PORTS) begin
			rd = {s.cfg.lport, s.cfg.rport};
			// RQ7 well-known ports refused
			wok = pwdata[31:16] >= tpf_pkg::TPF_MINPORT
				&& pwdata[15:0] >= tpf_pkg::TPF_MINPORT;
		end else if (paddr == tpf_pkg::TPF_A_IPCFG) begin
			rd = {1'b0, s.cfg.peer_pt, 1'b0, s.cfg.pt,
				s.cfg.tos, s.cfg.ttl};
		end else if (paddr == tpf_pkg::TPF_A_SSRC) begin
			rd = s.cfg.ssrc;
		end else if (paddr == tpf_pkg::TPF_A_STAT) begin
			rd = {14'h0000, s.rf, s.lf, s.seq_d};
		end else if (paddr == tpf_pkg::TPF_A_SEQ) begin
			rd = {16'(s.reord), 16'(s.lost)};
		end else begin
			hit = 1'b0;
			wok = 1'b0;
		end
	end

	// ************************************
	// next state
	// ************************************
	always_comb begin
		logic        ld;
		logic [1:0]  k;
		logic [4:0]  b;
		logic [15:0] ex;
		logic [15:0] df;
		ld = 1'b0;
		k  = tx_kind;
		b  = 5'h00;
		ex = 16'h0000;
		df = 16'h0000;
		n  = s;
		n.ok   = 1'b0;
		n.drop = 1'b0;
		// RQ11 RQ12 RQ13 fault follows defects
		n.lf = s.cfg.structured
			? (flt.los | flt.oof | flt.ais)
			: (flt.los | (s.cfg.ais_fault & flt.ais));
		// RQ14 remote flag follows state
		n.rf = flt.pkt_loss;

		// apb: one wait state, write at pready edge
		n.rdy = 1'b0;
		if (psel && penable && !s.rdy) begin
			n.rdy  = 1'b1;
			n.rdat = rd;
			n.err  = !hit || (pwrite && !wok);
		end
		if (psel && penable && s.rdy && pwrite && !s.err) begin
			if (paddr == tpf_pkg::TPF_A_CTRL) begin
				n.cfg.rtp_en     = pwdata[tpf_pkg::TPF_C_RTP];
				n.cfg.structured = pwdata[tpf_pkg::TPF_C_STR];
				n.cfg.ais_fault  = pwdata[tpf_pkg::TPF_C_AIS];
				n.cfg.src_chk    = pwdata[tpf_pkg::TPF_C_SRC];
				n.cfg.pt_chk     = pwdata[tpf_pkg::TPF_C_PT];
			end else if (paddr == tpf_pkg::TPF_A_SRCIP) begin
				n.cfg.sip = pwdata;
			end else if (paddr == tpf_pkg::TPF_A_DSTIP) begin
				n.cfg.dip = pwdata;
			end else if (paddr == tpf_pkg::TPF_A_PORTS) begin
				n.cfg.lport = pwdata[31:16];
				n.cfg.rport = pwdata[15:0];
			end else if (paddr == tpf_pkg::TPF_A_IPCFG) begin
				n.cfg.ttl     = pwdata[tpf_pkg::TPF_F_TTL +: 8];
				n.cfg.tos     = pwdata[tpf_pkg::TPF_F_TOS +: 8];
				n.cfg.pt      = pwdata[tpf_pkg::TPF_F_PT +: 7];
				n.cfg.peer_pt = pwdata[tpf_pkg::TPF_F_PPT +: 7];
			end else if (paddr == tpf_pkg::TPF_A_SSRC) begin
				n.cfg.ssrc = pwdata;
			end
		end

		// transmit fsm
		case (s.tx_st)
			tpf_pkg::TPF_TX_IDLE: begin
				if (tx_start) begin
					// RQ15 reserved kinds to normal
					// RQ16 fault forces kind 00
					if (s.lf || k == 2'b01
						|| (k == tpf_pkg::TPF_K_RAI
						&& !s.cfg.structured)) begin
						k = tpf_pkg::TPF_K_NORM;
					end
					n.kind = k;
					n.lf_p = s.lf;
					n.rf_p = s.rf;
					n.rtp  = s.cfg.rtp_en;
					n.len  = tx_len;
					n.id   = s.id + 16'h0001;
					// RQ22 shared timestamp, data advances
					n.ts   = s.ts_ctr;
					// RQ18 kind picks sequence space
					if (k == tpf_pkg::TPF_K_SIG) begin
						n.seq   = s.seq_s;
						n.seq_s = s.seq_s + 16'h0001;
					end else begin
						n.seq    = s.seq_d;
						n.seq_d  = s.seq_d + 16'h0001;
						n.ts_ctr = s.ts_ctr + {16'h0000, tx_len};
					end
					n.idx   = 4'h0;
					n.vld   = 1'b1;
					n.tx_st = tpf_pkg::TPF_TX_EMIT;
					ld      = 1'b1;
				end
			end
			tpf_pkg::TPF_TX_EMIT: begin
				// consumer may stall on tx_ready
				if (tx_ready && s.last) begin
					n.vld   = 1'b0;
					n.last  = 1'b0;
					n.tx_st = tpf_pkg::TPF_TX_IDLE;
				end else if (tx_ready) begin
					n.idx = s.idx + 4'h1;
					ld    = 1'b1;
				end
			end
			default: n.tx_st = tpf_pkg::TPF_TX_IDLE;
		endcase
		// RQ1 rtp words only when enabled
		if (ld) begin
			n.dat  = tpf_word(n);
			n.last = n.idx == (n.rtp ? tpf_pkg::TPF_W_RTP
				: tpf_pkg::TPF_W_NORTP);
		end

		// receive checks, word by word
		if (rx_valid) begin
			n.ridx = s.ridx + 4'h1;
			case (s.ridx)
				// RQ2 version must match flow
				4'h0: n.bad[tpf_pkg::TPF_D_VER] =
					rx_data[31:28] != s.cfg.ver;
				// RQ3 zero ttl dropped
				4'h2: n.bad[tpf_pkg::TPF_D_TTL] =
					rx_data[31:24] == 8'h00;
				4'h5: begin
					// RQ6 steer by destination port
					n.bad[tpf_pkg::TPF_D_PORT] =
						rx_data[15:0] != s.cfg.lport;
					n.bad[tpf_pkg::TPF_D_SRC] = s.cfg.src_chk
						&& rx_data[31:16] != s.cfg.rport;
				end
				4'h7: begin
					n.rkind = rx_data[25:24];
					n.rseq  = rx_data[15:0];
				end
				// RQ20 optional type check
				4'h8: n.bad[tpf_pkg::TPF_D_PT] = s.cfg.rtp_en
					&& s.cfg.pt_chk
					&& rx_data[22:16] != s.cfg.peer_pt;
				default: n.ridx = s.ridx + 4'h1;
			endcase
			if (rx_last) begin
				b      = n.bad;
				n.bad  = 5'h00;
				n.ridx = 4'h0;
				n.why  = b;
				// RQ23 bad packet touches no flow state
				if (b != 5'h00) begin
					n.drop = 1'b1;
				end else begin
					n.ok = 1'b1;
					// RQ18 loss and reorder per space
					if (n.rkind == tpf_pkg::TPF_K_SIG) begin
						ex = s.exp1;
					end else begin
						ex = s.exp0;
					end
					df = n.rseq - ex;
					if (!s.seen[n.rkind == tpf_pkg::TPF_K_SIG]
						|| df[15] == 1'b0) begin
						if (s.seen[n.rkind == tpf_pkg::TPF_K_SIG])
							n.lost = s.lost + CNT_W'(df);
						ex = n.rseq + 16'h0001;
					end else begin
						n.reord = s.reord + CNT_W'(1);
					end
					if (n.rkind == tpf_pkg::TPF_K_SIG) begin
						n.exp1    = ex;
						n.seen[1] = 1'b1;
					end else begin
						n.exp0    = ex;
						n.seen[0] = 1'b1;
					end
				end
			end
		end
	end

	// ************************************
	// state register
	// ************************************
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= ST_RST;
		end else begin
			s <= n;
		end
	end

	// outputs straight from state
	assign pready   = s.rdy;
	assign pslverr  = s.rdy & s.err;
	assign prdata   = s.rdat;
	assign tx_valid = s.vld;
	assign tx_data  = s.dat;
	assign tx_last  = s.last;
	assign rx_ok    = s.ok;
	assign rx_drop  = s.drop;
	assign rx_why   = s.why;
	assign rx_kind  = s.rkind;

	// ************************************
	// assertions
	// ************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	property p_df_flags;
		s.vld && s.idx == 4'h1 |-> s.dat[15:13] == 3'b010;
	endproperty
	a_df_flags: assert property (p_df_flags) // RQ4
		else $error("ipv4 flags not 010");

	property p_udp_len;
		s.vld && s.idx == 4'h6 |-> s.dat[31:16] == 16'h000c
			+ s.len + (s.rtp ? 16'h000c : 16'h0000)
			&& s.dat[15:0] == 16'h0000;
	endproperty
	a_udp_len: assert property (p_udp_len) // RQ8
		else $error("udp length or checksum wrong");

	property p_cw_res;
		s.vld && s.idx == 4'h7 |-> s.dat[31:28] == 4'h0
			&& s.dat[23:16] == 8'h00;
	endproperty
	a_cw_res: assert property (p_cw_res) // RQ17
		else $error("control word reserved bits set");

	property p_rtp_fix;
		s.vld && s.idx == 4'h8 |-> s.dat[31:30] == 2'h2
			&& s.dat[29:23] == 7'h00 && s.dat[15:0] == s.seq;
	endproperty
	a_rtp_fix: assert property (p_rtp_fix) // RQ19 RQ21
		else $error("rtp fixed bits or sequence wrong");

	property p_ttl_drop;
		rx_valid && rx_last && s.bad[tpf_pkg::TPF_D_TTL]
			|=> rx_drop && !rx_ok;
	endproperty
	a_ttl_drop: assert property (p_ttl_drop) // RQ3
		else $error("zero ttl not dropped");

	property p_port_miss;
		rx_valid && rx_last && s.bad[tpf_pkg::TPF_D_PORT]
			|=> $stable(s.exp0) && $stable(s.exp1)
			&& $stable(s.lost) && $stable(s.reord);
	endproperty
	a_port_miss: assert property (p_port_miss) // RQ23
		else $error("unmatched packet changed flow");

	property p_lf_str;
		s.cfg.structured && (flt.los || flt.oof || flt.ais)
			|=> s.lf ##1 s.lf || !$past(flt.los);
	endproperty
	a_lf_str: assert property (p_lf_str) // RQ12
		else $error("local fault missed");

	property p_rf_follow;
		$rose(flt.pkt_loss) |=> s.rf;
	endproperty
	a_rf_follow: assert property (p_rf_follow) // RQ14
		else $error("remote fault not set");

	property p_lf_kind;
		s.vld && s.idx == 4'h7 && s.dat[27] |-> s.dat[25:24] == 2'b00;
	endproperty
	a_lf_kind: assert property (p_lf_kind) // RQ16
		else $error("kind not 00 under fault");

	c_rtp_pkt: cover property (s.vld && s.last && s.idx == 4'ha);
	c_sig_pkt: cover property (s.vld && s.idx == 4'h7
		&& s.dat[25:24] == 2'b11);
	c_rx_ok:   cover property (rx_ok);
	c_refuse:  cover property (pready && pslverr);
endmodule

// ---- sim/tpf_peer.sv ----
/*
 * peer interworking_unit model: takes transmit header words with
 * optional stalls and sends receive header words built by the bench.
 * assumes one clock and that the bench fills rx_w before send.
 */
`timescale 1ns/1ps

module tpf_peer (
	// clock
	input  wire logic        core_clk,
	// words from the framer
	input  wire logic        tx_valid,
	input  wire logic [31:0] tx_data,
	input  wire logic        tx_last,
	output logic             tx_ready,
	// words to the framer
	output logic             rx_valid,
	output logic [31:0]      rx_data,
	output logic             rx_last
);
	logic [31:0] got [0:10];     // captured header words
	int          got_n   = 0;    // words captured so far
	int          last_at = -1;   // index where last flag came
	logic        slow    = 1'b0; // random back-pressure
	logic [31:0] rx_w [0:10];    // words queued by the bench

	initial begin
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_data  = '0;
		rx_last  = 1'b0;
	end

	// capture; stalls model a busy network side
	always @(posedge core_clk) begin
		if (tx_valid && tx_ready && got_n < 11) begin
			got[got_n] = tx_data;
			if (tx_last)
				last_at = got_n;
			got_n = got_n + 1;
		end
		tx_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
	end

	task automatic send(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk);
			rx_valid <= 1'b1;
			rx_data  <= rx_w[i];
			rx_last  <= (i == n - 1);
		end
		@(posedge core_clk);
		rx_valid <= 1'b0;
		rx_last  <= 1'b0;
		// released data never repeats the last word
		rx_data  <= ~rx_data;
	endtask
endmodule

// ---- sim/tpf_framer_bench.sv ----
/*
 * self-checking bench of the header framer: apb setup, random and
 * corner transmit packets, receive verdicts.
 * assumes tpf_pkg and tpf_peer are compiled first.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("Error t=%0t got=%h exp=%h", $time, g, e); \
	end \
end

module tpf_framer_bench;
	// ********
	// signals
	// ********
	logic        core_clk = 1'b0, arst_n = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = '0;
	logic [31:0] pwdata = '0, prdata, tx_data, rx_data;
	logic        pready, pslverr, tx_valid, tx_last, tx_ready;
	logic        rx_valid, rx_last, rx_ok, rx_drop;
	logic        tx_start = 1'b0;
	logic [1:0]  tx_kind = '0, rx_kind;
	logic [15:0] tx_len = '0;
	logic [4:0]  rx_why;
	tpf_pkg::tpf_flt_s flt = '0;
	int          error_cnt = 0, cmp_count = 0;
	// bench copy of the flow settings and trackers
	logic        rtp, strd, aisf, srcc, ptc, er, dsync, ssync, tsync;
	logic [15:0] lp, rp, dseq, sseq, id;
	logic [31:0] sip, dip, ssrc, rd, ts;
	logic [7:0]  ttl, tos;
	logic [6:0]  pt;

	always #10 core_clk = ~core_clk;

	tpf_framer dut_u (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .flt(flt), .tx_start(tx_start),
		.tx_kind(tx_kind), .tx_len(tx_len), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
		.rx_ok(rx_ok), .rx_drop(rx_drop), .rx_why(rx_why),
		.rx_kind(rx_kind));

	tpf_peer peer_u (.core_clk(core_clk), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last));

	// ********
	// tasks
	// ********
	task automatic close_out();
		$display("compares %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// one apb transfer, held until pready is sampled
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 40) begin
			error_cnt++;
			close_out();
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e,
		input logic ee);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
		`CHK(er, ee)
	endtask

	task automatic wchk(input logic [7:0] a, input logic [31:0] d,
		input logic ee);
		apb(1'b1, a, d);
		`CHK(er, ee)
	endtask

	task automatic wctrl();
		wchk(tpf_pkg::TPF_A_CTRL, {20'h0, tpf_pkg::TPF_IPV4, 3'h0,
			ptc, srcc, aisf, strd, rtp}, 1'b0);
	endtask

	// ones-complement sum of the five ip words, checksum included
	function automatic logic [15:0] hsum(input logic [31:0] w [0:10]);
		logic [19:0] c;
		c = 20'h00000;
		for (int i = 0; i < 5; i++)
			c = c + {4'h0, w[i][31:16]} + {4'h0, w[i][15:0]};
		c = {4'h0, c[15:0]} + {16'h0000, c[19:16]};
		c = {4'h0, c[15:0]} + {16'h0000, c[19:16]};
		return c[15:0];
	endfunction

	// send one packet and compare every header word
	task automatic tx_pkt(input logic [1:0] k, input logic [15:0] len);
		int          n, nw;
		logic        lf;
		logic [1:0]  ek;
		logic [15:0] ul, sq;
		logic [31:0] w [0:10];
		peer_u.got_n   = 0;
		peer_u.last_at = -1;
		// faults mirror one cycle late: let them settle
		repeat (2) @(posedge core_clk);
		lf = flt.los | (strd ? (flt.oof | flt.ais) : (aisf & flt.ais));
		ek = (lf || k == 2'b01 || (k == 2'b10 && !strd)) ? 2'b00 : k;
		nw = rtp ? 11 : 8;
		ul = tpf_pkg::TPF_L_UDPCW + (rtp ? tpf_pkg::TPF_L_RTP : 16'h0)
			+ len;
		tx_start <= 1'b1;
		tx_kind  <= k;
		tx_len   <= len;
		@(posedge core_clk);
		tx_start <= 1'b0;
		n = 0;
		while (peer_u.got_n < nw && n < 300) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 300) begin
			error_cnt++;
			close_out();
		end
		w  = peer_u.got;
		sq = w[7][15:0];
		if (ek == 2'b11) begin
			if (ssync) `CHK(sq, sseq)
			sseq  = sq + 16'h1;
			ssync = 1'b1;
		end else begin
			if (dsync) `CHK(sq, dseq)
			dseq  = sq + 16'h1;
			dsync = 1'b1;
		end
		`CHK(peer_u.last_at, nw - 1)
		`CHK(w[0], {8'h45, tos, ul + tpf_pkg::TPF_L_IP})
		`CHK(w[1], {id, tpf_pkg::TPF_DF, 13'h0})
		`CHK(w[2][31:16], {ttl, tpf_pkg::TPF_UDP})
		`CHK(hsum(w), 16'hffff)
		`CHK({w[3], w[4], w[5]}, {sip, dip, lp, rp})
		`CHK(w[6], {ul, 16'h0})
		`CHK(w[7][31:16], {4'h0, lf, flt.pkt_loss, ek, 8'h0})
		if (rtp) begin
			`CHK(w[8], {8'h80, 1'b0, pt, sq})
			`CHK(w[10], ssrc)
			if (ek != 2'b11) begin
				if (tsync) `CHK(w[9], ts)
				ts    = w[9] + 32'(len);
				tsync = 1'b1;
			end else if (tsync) `CHK(w[9], ts)
		end
		id = id + 16'h1;
	endtask

	// one received header, then its verdict
	task automatic rx_pkt(input logic [3:0] v, input logic [7:0] tl,
		input logic [15:0] sp, input logic [15:0] dp,
		input logic [1:0] k, input logic [15:0] s, input logic [4:0] ew);
		int n;
		peer_u.rx_w[0] = {v, 4'h5, 8'h00, 16'h0020};
		peer_u.rx_w[1] = 32'h00014000;
		peer_u.rx_w[2] = {tl, 8'h11, 16'h0000};
		peer_u.rx_w[3] = dip;
		peer_u.rx_w[4] = sip;
		peer_u.rx_w[5] = {sp, dp};
		peer_u.rx_w[6] = 32'h000c0000;
		peer_u.rx_w[7] = {6'h00, k, 8'h00, s};
		// payload type 1 only when a type refusal is wanted
		peer_u.rx_w[8] = {9'h100, 6'h00, ew[4], s};
		peer_u.rx_w[9] = 32'h0;
		peer_u.rx_w[10] = ssrc;
		peer_u.send(rtp ? 11 : 8);
		n = 0;
		while (rx_ok !== 1'b1 && rx_drop !== 1'b1 && n < 10) begin
			@(negedge core_clk);
			n++;
		end
		`CHK(rx_ok | rx_drop, 1'b1)
		`CHK(rx_drop, |ew)
		`CHK(rx_why, ew)
		if (ew == 5'h0) `CHK(rx_kind, k)
	endtask

	// ********
	// main sequence
	// ********
	initial begin
		void'($urandom(5577));
		{rtp, strd, aisf, srcc, ptc, dsync, ssync, tsync} = '0;
		id = 16'h1;
		repeat (6) @(posedge core_clk);
		arst_n <= 1'b1;
		rchk(tpf_pkg::TPF_A_CTRL, 32'h400, 1'b0);
		rchk(tpf_pkg::TPF_A_PORTS, 32'hc000c000, 1'b0);
		rchk(8'h20, 32'h0, 1'b1);
		wchk(tpf_pkg::TPF_A_CTRL, 32'h600, 1'b1);
		wchk(tpf_pkg::TPF_A_PORTS, 32'h03ffc000, 1'b1);
		wchk(tpf_pkg::TPF_A_PORTS, 32'hc00003ff, 1'b1);
		wchk(tpf_pkg::TPF_A_PORTS, 32'h04000400, 1'b0);
		rchk(tpf_pkg::TPF_A_PORTS, 32'h04000400, 1'b0);
		lp   = {2'b11, 14'($urandom)};
		rp   = {2'b11, 14'($urandom)};
		sip  = $urandom;
		dip  = $urandom;
		ssrc = $urandom;
		ttl  = 8'($urandom_range(1, 255));
		tos  = 8'($urandom);
		pt   = 7'($urandom);
		wchk(tpf_pkg::TPF_A_SRCIP, sip, 1'b0);
		wchk(tpf_pkg::TPF_A_DSTIP, dip, 1'b0);
		wchk(tpf_pkg::TPF_A_SSRC, ssrc, 1'b0);
		wchk(tpf_pkg::TPF_A_PORTS, {lp, rp}, 1'b0);
		wchk(tpf_pkg::TPF_A_IPCFG, {9'h0, pt, tos, ttl}, 1'b0);
		// every kind in both modes, no fault
		for (int i = 0; i < 8; i++) begin
			strd = i[2];
			wctrl();
			tx_pkt(i[1:0], 16'd192);
		end
		// random modes, faults, kinds and lengths
		for (int i = 0; i < 40; i++) begin
			strd = 1'($urandom);
			aisf = 1'($urandom);
			wctrl();
			flt <= tpf_pkg::tpf_flt_s'(4'($urandom) & {4{1'($urandom)}});
			tx_pkt(2'($urandom), 16'($urandom_range(20, 1500)));
		end
		// rtp header with a stalling peer
		rtp         = 1'b1;
		peer_u.slow = 1'b1;
		for (int i = 0; i < 12; i++) begin
			strd = 1'($urandom);
			wctrl();
			flt <= tpf_pkg::tpf_flt_s'(4'($urandom) & {4{1'($urandom)}});
			tx_pkt(2'($urandom), 16'd256);
		end
		// receive side
		rtp         = 1'b0;
		peer_u.slow = 1'b0;
		wctrl();
		flt <= '0;
		rchk(tpf_pkg::TPF_A_STAT, {16'h0, dseq}, 1'b0);
		rx_pkt(4'h4, 8'h40, rp, lp, 2'b00, 16'd100, 5'h00);
		rx_pkt(4'h4, 8'h40, rp, lp ^ 16'h1, 2'b00, 16'd200, 5'h04);
		rx_pkt(4'h4, 8'h40, rp, lp, 2'b00, 16'd101, 5'h00);
		rx_pkt(4'h4, 8'h00, rp, lp, 2'b00, 16'd150, 5'h01);
		rx_pkt(4'h6, 8'h40, rp, lp, 2'b00, 16'd160, 5'h02);
		rx_pkt(4'h4, 8'h40, rp, lp, 2'b00, 16'd102, 5'h00);
		rx_pkt(4'h4, 8'h40, rp, lp, 2'b10, 16'd103, 5'h00);
		rx_pkt(4'h4, 8'h40, rp, lp, 2'b11, 16'd7, 5'h00);
		// two lost, then one late arrival
		rx_pkt(4'h4, 8'h40, rp, lp, 2'b00, 16'd106, 5'h00);
		rx_pkt(4'h4, 8'h40, rp, lp, 2'b00, 16'd50, 5'h00);
		srcc = 1'b1;
		wctrl();
		rx_pkt(4'h4, 8'h40, rp ^ 16'h1, lp, 2'b00, 16'd170, 5'h08);
		// rtp headers with the payload type check on
		{rtp, srcc, ptc} = 3'b101;
		wctrl();
		rx_pkt(4'h4, 8'h40, rp, lp, 2'b00, 16'd108, 5'h10);
		rx_pkt(4'h4, 8'h40, rp, lp, 2'b00, 16'd107, 5'h00);
		rchk(tpf_pkg::TPF_A_SEQ, 32'h00010002, 1'b0);
		close_out();
	end
endmodule
